// [counter_array_pkg.sv]
// Constants, register map and mode codes for the counter array
package counter_array_pkg;
	localparam int MODULE_COUNT = 6;
	localparam int WATCHDOG_MODULE = 5;
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h01;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h02;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h03;
	localparam logic [7:0] ADDR_MODULE_MODE = 8'h10;
	localparam logic [7:0] ADDR_VALUE_LOW = 8'h18;
	localparam logic [7:0] ADDR_VALUE_HIGH = 8'h20;
	// Control register fields
	localparam int CTL_OVERFLOW = 7;
	localparam int CTL_RUN = 6;
	// Array mode register fields
	localparam int MD_IDLE_SUSPEND = 7;
	localparam int MD_WATCHDOG = 6;
	localparam int MD_TB_HI = 3;
	localparam int MD_TB_LO = 1;
	localparam int MD_OVF_IE = 0;
	localparam logic [7:0] MODE_RESET = 8'h40;
	// Module mode register fields
	localparam int MM_WIDE = 7;
	localparam int MM_COMP = 6;
	localparam int MM_RISE = 5;
	localparam int MM_FALL = 4;
	localparam int MM_MATCH = 3;
	localparam int MM_TOGGLE = 2;
	localparam int MM_PWM = 1;
	localparam int MM_IE = 0;
	localparam logic [7:0] MODULE_MODE_RESET = 8'h00;
	localparam logic [7:0] WATCHDOG_MODE_FORCED = 8'h48;
	// Timebase codes
	localparam logic [2:0] TB_DIV12 = 3'h0;
	localparam logic [2:0] TB_DIV4 = 3'h1;
	localparam logic [2:0] TB_TIMER0 = 3'h2;
	localparam logic [2:0] TB_EXT_INPUT = 3'h3;
	localparam logic [2:0] TB_SYSCLK = 3'h4;
	localparam logic [2:0] TB_EXT_OSC = 3'h5;
	localparam logic [2:0] TB_RTC = 3'h6;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	typedef enum logic [6:0] {
		MODE_IDLE = 7'h01,
		MODE_CAPTURE = 7'h02,
		MODE_SW_TIMER = 7'h04,
		MODE_HS_OUTPUT = 7'h08,
		MODE_FREQ_OUTPUT = 7'h10,
		MODE_PWM8 = 7'h20,
		MODE_WIDE_PWM_SELECT = 7'h40
	} module_mode_type;
endpackage

// [counter_array.sv]
// Counter array: 16-bit timebase counter with six capture/compare modules
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module counter_array
	import counter_array_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] address,
	input wire logic [7:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [7:0] read_data,
	input wire logic timer0_overflow,
	input wire logic external_count_input,
	input wire logic ext_osc_div8,
	input wire logic rtc_div8,
	input wire logic cpu_idle,
	input wire logic global_interrupt_enable,
	input wire logic array_group_interrupt_enable,
	input wire logic [5:0] module_pin,
	output logic [5:0] module_pin_route,
	output logic interrupt_request
);
	logic [15:0] count_reg;
	logic [7:0] snapshot_reg;
	logic [7:0] array_mode_reg;
	logic counter_run_reg;
	logic counter_overflow_flag_reg;
	logic [5:0] module_event_flag_reg;
	logic [7:0] module_mode_reg [MODULE_COUNT];
	logic [15:0] module_value_reg [MODULE_COUNT];
	logic [3:0] div12_reg;
	logic [1:0] div4_reg;
	logic [2:0] eci_sync_reg;
	logic [2:0] osc_sync_reg;
	logic [2:0] rtc_sync_reg;
	logic [5:0] pin_sync1_reg;
	logic [5:0] pin_sync2_reg;
	logic [5:0] pin_prev_reg;
	logic tick;
	logic advance;
	logic watchdog_on;
	logic [15:0] count_next;
	logic [5:0] capture_hit;
	logic [5:0] match_hit;
	logic wr_control;
	logic wr_mode;
	// Per-module flag enables, gathered so the request logic needs no hierarchy
	logic [5:0] irq_enable_bits;

	function automatic module_mode_type decode_mode(input logic [7:0] m);
		if (m[MM_RISE] || m[MM_FALL])
			decode_mode = (m[MM_MATCH] || m[MM_TOGGLE] || m[MM_PWM]) ? MODE_IDLE : MODE_CAPTURE;
		else if (!m[MM_COMP])
			decode_mode = MODE_IDLE;
		else if (m[MM_PWM] && m[MM_TOGGLE])
			decode_mode = MODE_FREQ_OUTPUT;
		else if (m[MM_PWM])
			decode_mode = m[MM_WIDE] ? MODE_WIDE_PWM_SELECT : MODE_PWM8;
		else if (m[MM_MATCH] && m[MM_TOGGLE])
			decode_mode = MODE_HS_OUTPUT;
		else if (m[MM_MATCH])
			decode_mode = MODE_SW_TIMER;
		else
			decode_mode = MODE_IDLE;
	endfunction

	assign watchdog_on = array_mode_reg[MD_WATCHDOG];
	assign wr_control = write_strobe && address == ADDR_CONTROL;
	assign wr_mode = write_strobe && address == ADDR_MODE;

	// Prescalers run free; they are cheap and keep tick phase simple
	always_ff @(posedge clk)
	begin
		if (reset || div12_reg == DIV12_LAST)
			div12_reg <= 4'h0;
		else
			div12_reg <= div12_reg + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			div4_reg <= 2'h0;
		else
			div4_reg <= div4_reg + 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			eci_sync_reg <= 3'h0;
			osc_sync_reg <= 3'h0;
			rtc_sync_reg <= 3'h0;
		end
		else
		begin
			eci_sync_reg <= {eci_sync_reg[1:0], external_count_input};
			osc_sync_reg <= {osc_sync_reg[1:0], ext_osc_div8};
			rtc_sync_reg <= {rtc_sync_reg[1:0], rtc_div8};
		end
	end

	always_comb
	begin
		case (array_mode_reg[MD_TB_HI:MD_TB_LO])
			TB_DIV12: tick = div12_reg == DIV12_LAST;
			TB_DIV4: tick = div4_reg == DIV4_LAST;
			TB_TIMER0: tick = timer0_overflow;
			TB_EXT_INPUT: tick = eci_sync_reg[2] && !eci_sync_reg[1];
			TB_SYSCLK: tick = 1'b1;
			TB_EXT_OSC: tick = osc_sync_reg[1] && !osc_sync_reg[2];
			TB_RTC: tick = rtc_sync_reg[1] && !rtc_sync_reg[2];
			default: tick = 1'b0;
		endcase
	end

	// Watchdog forces the counter on regardless of run control
	assign advance = tick && (counter_run_reg || watchdog_on)
		&& !(cpu_idle && array_mode_reg[MD_IDLE_SUSPEND]);
	assign count_next = count_reg + 16'h0001;

	always_ff @(posedge clk)
	begin
		if (reset)
			count_reg <= 16'h0000;
		else if (write_strobe && address == ADDR_COUNT_LOW && !watchdog_on)
			count_reg[7:0] <= write_data;
		else if (write_strobe && address == ADDR_COUNT_HIGH && !watchdog_on)
			count_reg[15:8] <= write_data;
		else if (advance)
			count_reg <= count_next;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			snapshot_reg <= 8'h00;
		else if (read_strobe && address == ADDR_COUNT_LOW)
			snapshot_reg <= count_reg[15:8];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			array_mode_reg <= MODE_RESET;
		else if (wr_mode)
		begin
			array_mode_reg[MD_WATCHDOG] <= write_data[MD_WATCHDOG];
			array_mode_reg[MD_OVF_IE] <= write_data[MD_OVF_IE];
			if (!watchdog_on)
			begin
				array_mode_reg[MD_IDLE_SUSPEND] <= write_data[MD_IDLE_SUSPEND];
				array_mode_reg[MD_TB_HI:MD_TB_LO] <= write_data[MD_TB_HI:MD_TB_LO];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			counter_run_reg <= 1'b0;
		else if (wr_control)
			counter_run_reg <= write_data[CTL_RUN];
	end

	// Hardware set wins over a same-cycle software clear
	always_ff @(posedge clk)
	begin
		if (reset)
			counter_overflow_flag_reg <= 1'b0;
		else if (advance && count_reg == COUNT_MAX)
			counter_overflow_flag_reg <= 1'b1;
		else if (wr_control)
			counter_overflow_flag_reg <= write_data[CTL_OVERFLOW];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin_sync1_reg <= 6'h00;
			pin_sync2_reg <= 6'h00;
			pin_prev_reg <= 6'h00;
		end
		else
		begin
			pin_sync1_reg <= module_pin;
			pin_sync2_reg <= pin_sync1_reg;
			pin_prev_reg <= pin_sync2_reg;
		end
	end

	genvar n;
	generate
		for (n = 0; n < MODULE_COUNT; n++)
		begin : modules
			module_mode_type mode;
			logic [7:0] mode_eff;
			assign mode_eff = (n == WATCHDOG_MODULE && watchdog_on) ? WATCHDOG_MODE_FORCED : module_mode_reg[n];
			assign mode = decode_mode(mode_eff);
			assign capture_hit[n] = mode == MODE_CAPTURE
				&& ((mode_eff[MM_RISE] && pin_sync2_reg[n] && !pin_prev_reg[n])
				|| (mode_eff[MM_FALL] && !pin_sync2_reg[n] && pin_prev_reg[n]));
			assign match_hit[n] = mode == MODE_SW_TIMER && advance
				&& count_next == module_value_reg[n];
			assign module_pin_route[n] = mode != MODE_IDLE;
			assign irq_enable_bits[n] = mode_eff[MM_IE];

			always_ff @(posedge clk)
			begin
				if (reset)
					module_mode_reg[n] <= MODULE_MODE_RESET;
				else if (write_strobe && address == ADDR_VALUE_LOW + 8'(n))
					module_mode_reg[n][MM_COMP] <= 1'b0;
				else if (write_strobe && address == ADDR_VALUE_HIGH + 8'(n))
					module_mode_reg[n][MM_COMP] <= 1'b1;
				else if (write_strobe && address == ADDR_MODULE_MODE + 8'(n)
					&& !(n == WATCHDOG_MODULE && watchdog_on))
					module_mode_reg[n] <= write_data;
			end

			always_ff @(posedge clk)
			begin
				if (reset)
					module_value_reg[n] <= 16'h0000;
				else if (capture_hit[n])
					module_value_reg[n] <= count_reg;
				else if (write_strobe && address == ADDR_VALUE_LOW + 8'(n))
					module_value_reg[n][7:0] <= write_data;
				else if (write_strobe && address == ADDR_VALUE_HIGH + 8'(n))
					module_value_reg[n][15:8] <= write_data;
			end

			always_ff @(posedge clk)
			begin
				if (reset)
					module_event_flag_reg[n] <= 1'b0;
				else if (capture_hit[n] || match_hit[n])
					module_event_flag_reg[n] <= 1'b1;
				else if (wr_control)
					module_event_flag_reg[n] <= write_data[n];
			end

			// Every module checked, module 5 too while the watchdog forces its mode
			event_set_a: assert property (@(posedge clk) disable iff (reset)
				capture_hit[n] || match_hit[n] |=> module_event_flag_reg[n])
				else $error("module flag not set");
			event_hold_a: assert property (@(posedge clk) disable iff (reset)
				module_event_flag_reg[n] && !wr_control |=> module_event_flag_reg[n])
				else $error("module flag cleared without write");
			comp_high_a: assert property (@(posedge clk) disable iff (reset)
				write_strobe && address == ADDR_VALUE_HIGH + 8'(n) |=> module_mode_reg[n][MM_COMP])
				else $error("high byte write left comparator off");
			value_low_a: assert property (@(posedge clk) disable iff (reset)
				write_strobe && address == ADDR_VALUE_LOW + 8'(n) && !capture_hit[n]
				|=> module_value_reg[n][7:0] == $past(write_data))
				else $error("value low byte not written");
			value_high_a: assert property (@(posedge clk) disable iff (reset)
				write_strobe && address == ADDR_VALUE_HIGH + 8'(n) && !capture_hit[n]
				|=> module_value_reg[n][15:8] == $past(write_data))
				else $error("value high byte not written");
			capture_value_a: assert property (@(posedge clk) disable iff (reset)
				capture_hit[n] |=> module_value_reg[n] == $past(count_reg))
				else $error("capture value wrong");
		end
	endgenerate

	always_comb
	begin
		interrupt_request = global_interrupt_enable && array_group_interrupt_enable
			&& ((counter_overflow_flag_reg && array_mode_reg[MD_OVF_IE])
			|| |(module_event_flag_reg & irq_enable_bits));
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			read_data <= 8'h00;
		else if (!read_strobe)
			read_data <= 8'h00;
		else
		begin
			read_data <= 8'h00;
			if (address == ADDR_CONTROL)
				read_data <= {counter_overflow_flag_reg, counter_run_reg, module_event_flag_reg};
			else if (address == ADDR_MODE)
				read_data <= array_mode_reg;
			else if (address == ADDR_COUNT_LOW)
				read_data <= count_reg[7:0];
			else if (address == ADDR_COUNT_HIGH)
				read_data <= snapshot_reg;
			else
				for (int k = 0; k < MODULE_COUNT; k++)
				begin
					if (address == ADDR_MODULE_MODE + 8'(k))
						read_data <= module_mode_reg[k];
					if (address == ADDR_VALUE_LOW + 8'(k))
						read_data <= module_value_reg[k][7:0];
					if (address == ADDR_VALUE_HIGH + 8'(k))
						read_data <= module_value_reg[k][15:8];
				end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	overflow_flag_set_a: assert property (advance && count_reg == COUNT_MAX |=> counter_overflow_flag_reg)
		else $error("overflow flag not set on wrap");
	count_hold_a: assert property (!advance && !write_strobe |=> $stable(count_reg))
		else $error("counter moved without tick");
	count_step_a: assert property (advance && !write_strobe |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not step");
	count_run_a: assert property (!counter_run_reg && !watchdog_on && !write_strobe
		|=> $stable(count_reg))
		else $error("counter moved while stopped");
	snapshot_read_a: assert property (read_strobe && address == ADDR_COUNT_LOW ##1 read_strobe
		&& address == ADDR_COUNT_HIGH |=> read_data == $past(count_reg[15:8], 2))
		else $error("high byte read not from snapshot");
	snapshot_hold_a: assert property (!(read_strobe && address == ADDR_COUNT_LOW)
		|=> $stable(snapshot_reg))
		else $error("snapshot moved without low read");
	idle_stop_a: assert property (cpu_idle && array_mode_reg[MD_IDLE_SUSPEND] && !write_strobe
		|=> $stable(count_reg))
		else $error("counter advanced in idle suspend");
	idle_run_a: assert property (cpu_idle && !array_mode_reg[MD_IDLE_SUSPEND] && counter_run_reg
		&& tick && !write_strobe |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter stalled in idle");
	div12_gap_a: assert property (array_mode_reg[MD_TB_HI:MD_TB_LO] == TB_DIV12 && tick && !wr_mode
		|=> !tick)
		else $error("divide by 12 ticked twice in a row");
	irq_gate_a: assert property (!global_interrupt_enable || !array_group_interrupt_enable |-> !interrupt_request)
		else $error("interrupt without global enables");
	low_write_comp_a: assert property (write_strobe && address == ADDR_VALUE_LOW + 8'h01
		|=> !module_mode_reg[1][MM_COMP])
		else $error("low byte write kept comparator enable");
	capture_load_a: assert property (capture_hit[0] |=> module_value_reg[0] == $past(count_reg)
		&& module_event_flag_reg[0])
		else $error("capture did not load value");
	match_flag_a: assert property (match_hit[1] |=> module_event_flag_reg[1])
		else $error("match flag not set");
	overflow_irq_a: assert property (global_interrupt_enable && array_group_interrupt_enable
		&& counter_overflow_flag_reg && array_mode_reg[MD_OVF_IE] |-> interrupt_request)
		else $error("overflow interrupt missing");
	module_irq_a: assert property (global_interrupt_enable && array_group_interrupt_enable
		&& module_event_flag_reg[0] && module_mode_reg[0][MM_IE] |-> interrupt_request)
		else $error("module interrupt missing");
	overflow_hold_a: assert property (counter_overflow_flag_reg && !wr_control
		|=> counter_overflow_flag_reg)
		else $error("overflow flag cleared without write");
	overflow_clear_a: assert property (wr_control && !(advance && count_reg == COUNT_MAX)
		|=> counter_overflow_flag_reg == $past(write_data[CTL_OVERFLOW]))
		else $error("overflow flag ignored control write");

	// Watchdog locks keep runaway code from retuning the counter it relies on
	watchdog_count_a: assert property (watchdog_on && write_strobe && !advance
		&& (address == ADDR_COUNT_LOW || address == ADDR_COUNT_HIGH) |=> $stable(count_reg))
		else $error("count written while watchdog on");
	watchdog_mode_a: assert property (watchdog_on && write_strobe
		&& address == ADDR_MODULE_MODE + 8'(WATCHDOG_MODULE) |=> $stable(module_mode_reg[WATCHDOG_MODULE]))
		else $error("watchdog module mode written");
	watchdog_route_a: assert property (watchdog_on |-> module_pin_route[WATCHDOG_MODULE])
		else $error("watchdog module not routed");
	read_idle_a: assert property (!read_strobe |=> read_data == 8'h00)
		else $error("read data without strobe");

	wrap_c: cover property (advance && count_reg == COUNT_MAX);
	capture_c: cover property (capture_hit[0]);
	match_c: cover property (match_hit[1]);
	irq_c: cover property (interrupt_request);
	idle_hold_c: cover property (cpu_idle && array_mode_reg[MD_IDLE_SUSPEND] && tick);
endmodule

// [counter_array_partner.sv]
// External signal sources facing the counter array pins and timebase inputs
`timescale 1ns/1ps
module counter_array_partner
(
	input wire logic clk,
	input wire logic [5:0] pin_request,
	output logic [5:0] module_pin,
	output logic timer0_overflow,
	output logic external_count_input,
	output logic ext_osc_div8,
	output logic rtc_div8
);
	logic [2:0] phase_reg;
	initial
	begin
		phase_reg = 3'h0;
		module_pin = 6'h00;
		timer0_overflow = 1'b0;
		external_count_input = 1'b1;
		ext_osc_div8 = 1'b0;
		rtc_div8 = 1'b0;
	end
	// Oscillators free-run with no phase tie to clk
	always #83 ext_osc_div8 = ~ext_osc_div8;
	always #119 rtc_div8 = ~rtc_div8;
	always @(posedge clk)
	begin
		phase_reg <= phase_reg + 3'h1;
		timer0_overflow <= (phase_reg == 3'h7);
		external_count_input <= phase_reg[2];
		module_pin <= pin_request;
	end
endmodule

// [test_counter_array.sv]
// Self-checking testbench for the counter array
`timescale 1ns/1ps
module test_counter_array;
	import counter_array_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] address = 8'h00;
	logic [7:0] write_data = 8'h00;
	logic write_strobe = 1'b0;
	logic read_strobe = 1'b0;
	logic cpu_idle = 1'b0;
	logic global_interrupt_enable = 1'b0;
	logic array_group_interrupt_enable = 1'b0;
	logic [5:0] pin_request = 6'h00;
	logic [7:0] read_data;
	logic timer0_overflow, external_count_input, ext_osc_div8, rtc_div8, interrupt_request;
	logic [5:0] module_pin, module_pin_route;
	logic [7:0] rd, lo;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycle_cnt = 0;
	always #5 clk = ~clk;
	counter_array counter_array_inst (.clk(clk), .reset(reset), .address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
		.timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
		.ext_osc_div8(ext_osc_div8), .rtc_div8(rtc_div8), .cpu_idle(cpu_idle),
		.global_interrupt_enable(global_interrupt_enable),
		.array_group_interrupt_enable(array_group_interrupt_enable), .module_pin(module_pin),
		.module_pin_route(module_pin_route), .interrupt_request(interrupt_request));
	counter_array_partner counter_array_partner_inst (.clk(clk), .pin_request(pin_request),
		.module_pin(module_pin), .timer0_overflow(timer0_overflow),
		.external_count_input(external_count_input), .ext_osc_div8(ext_osc_div8), .rtc_div8(rtc_div8));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clk);
		read_strobe <= 1'b0;
		#1 rd = read_data;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_range(input string what, input logic [15:0] l, input logic [15:0] h, input logic [15:0] got);
		samples_checked++;
		if ((got >= l && got <= h) !== 1'b1)
		begin
			error_cnt++;
			$display("BAD %s expected %h..%h seen %h", what, l, h, got);
		end
	endtask
	task automatic irq(input logic g, input logic a, input logic exp);
		@(posedge clk);
		global_interrupt_enable <= g;
		array_group_interrupt_enable <= a;
		@(posedge clk);
		#1 chk("interrupt", {7'h00, exp}, {7'h00, interrupt_request});
	endtask
	task automatic test_reset;
		rdr(ADDR_MODE);
		chk("array mode", MODE_RESET, rd);
		chk("pin route", 8'h20, {2'h0, module_pin_route});
		wr(ADDR_COUNT_LOW, 8'haa);
		wr(ADDR_MODULE_MODE + 8'h05, 8'h00);
		rdr(ADDR_COUNT_LOW);
		chk_range("locked count", 16'h0000, 16'h0010, {8'h00, rd});
		chk("locked route", 8'h20, {2'h0, module_pin_route});
		$display("test_reset done");
	endtask
	task automatic test_timebase;
		int div[7] = '{12, 4, 8, 8, 1, 17, 24};
		logic [15:0] exp;
		for (int tb = 0; tb < 7; tb++)
		begin
			wr(ADDR_CONTROL, 8'h00);
			wr(ADDR_MODE, {4'h0, tb[2:0], 1'b0});
			wr(ADDR_COUNT_LOW, 8'h00);
			wr(ADDR_COUNT_HIGH, 8'h00);
			wr(ADDR_CONTROL, 8'h40);
			repeat (240) @(posedge clk);
			wr(ADDR_CONTROL, 8'h00);
			rdr(ADDR_COUNT_LOW);
			exp = 16'(240 / div[tb]);
			chk_range("timebase count", exp - 16'h3, exp + 16'h3, {8'h00, rd});
		end
		$display("test_timebase done");
	endtask
	task automatic test_overflow;
		wr(ADDR_MODE, 8'h09);
		wr(ADDR_COUNT_LOW, 8'hfc);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_CONTROL, 8'h40);
		// Low then high read back to back, as software would do it
		@(posedge clk);
		address <= ADDR_COUNT_LOW;
		read_strobe <= 1'b1;
		@(posedge clk);
		address <= ADDR_COUNT_HIGH;
		#1 lo = read_data;
		@(posedge clk);
		read_strobe <= 1'b0;
		#1 rd = read_data;
		chk_range("count snapshot", 16'hfffc, 16'hffff, {rd, lo});
		@(posedge clk);
		rdr(ADDR_COUNT_LOW);
		chk_range("count after reads", 16'h0001, 16'h0040, {8'h00, rd});
		rdr(ADDR_CONTROL);
		chk("overflow flag", 8'h80, rd & 8'h80);
		irq(1'b0, 1'b1, 1'b0);
		irq(1'b1, 1'b0, 1'b0);
		irq(1'b1, 1'b1, 1'b1);
		wr(ADDR_MODE, 8'h08);
		irq(1'b1, 1'b1, 1'b0);
		wr(ADDR_MODE, 8'h09);
		repeat (20) @(posedge clk);
		irq(1'b1, 1'b1, 1'b1);
		wr(ADDR_CONTROL, 8'h00);
		irq(1'b1, 1'b1, 1'b0);
		$display("test_overflow done");
	endtask
	task automatic test_capture;
		logic [7:0] modes[4] = '{8'h21, 8'h11, 8'h31, 8'h20};
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_COUNT_LOW, 8'h56);
		wr(ADDR_COUNT_HIGH, 8'h34);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_MODULE_MODE, modes[i]);
			wr(ADDR_CONTROL, 8'h00);
			pin_request <= 6'h01;
			repeat (8) @(posedge clk);
			rdr(ADDR_CONTROL);
			chk("rise flag", {7'h00, modes[i][5]}, rd & 8'h01);
			#1 chk("capture irq", {7'h00, modes[i][5] & modes[i][0]}, {7'h00, interrupt_request});
			wr(ADDR_CONTROL, 8'h00);
			pin_request <= 6'h00;
			repeat (8) @(posedge clk);
			rdr(ADDR_CONTROL);
			chk("fall flag", {7'h00, modes[i][4]}, rd & 8'h01);
		end
		rdr(ADDR_VALUE_LOW);
		chk("capture low", 8'h56, rd);
		rdr(ADDR_VALUE_HIGH);
		chk("capture high", 8'h34, rd);
		$display("test_capture done");
	endtask
	task automatic test_timer;
		wr(ADDR_MODULE_MODE + 8'h01, 8'h48);
		wr(ADDR_VALUE_LOW + 8'h01, 8'h14);
		rdr(ADDR_MODULE_MODE + 8'h01);
		chk("mode after low", 8'h08, rd);
		wr(ADDR_VALUE_HIGH + 8'h01, 8'h00);
		rdr(ADDR_MODULE_MODE + 8'h01);
		chk("mode after high", 8'h48, rd);
		chk("timer route", 8'h02, {2'h0, module_pin_route} & 8'h02);
		wr(ADDR_MODE, 8'h08);
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_CONTROL, 8'h40);
		rdr(ADDR_CONTROL);
		chk("early match", 8'h00, rd & 8'h02);
		repeat (30) @(posedge clk);
		rdr(ADDR_CONTROL);
		chk("match flag", 8'h02, rd & 8'h02);
		$display("test_timer done");
	endtask
	task automatic test_modes;
		logic [7:0] codes[6] = '{8'h4c, 8'h46, 8'h42, 8'hc2, 8'h28, 8'h08};
		logic routed[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 6; i++)
		begin
			wr(ADDR_MODULE_MODE + 8'h02, codes[i]);
			#1 chk("mode route", {7'h00, routed[i]}, {7'h00, module_pin_route[2]});
		end
		wr(ADDR_MODULE_MODE + 8'h02, 8'h00);
		$display("test_modes done");
	endtask
	task automatic test_idle;
		wr(ADDR_MODE, 8'h88);
		@(posedge clk);
		cpu_idle <= 1'b1;
		rdr(ADDR_COUNT_LOW);
		lo = rd;
		repeat (10) @(posedge clk);
		rdr(ADDR_COUNT_LOW);
		chk("idle hold", lo, rd);
		wr(ADDR_MODE, 8'h08);
		rdr(ADDR_COUNT_LOW);
		lo = rd;
		repeat (10) @(posedge clk);
		rdr(ADDR_COUNT_LOW);
		chk("idle run", lo + 8'h0c, rd);
		cpu_idle <= 1'b0;
		$display("test_idle done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycle_cnt++;
		if (cycle_cnt == 20000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_timebase();
		test_overflow();
		test_capture();
		test_timer();
		test_modes();
		test_idle();
		wrap_up();
	end
endmodule
